// *** hw/vgp_pkg.sv ***
package vgp_pkg;

  // Graphics controller register indices on the indexed data port.
  localparam logic [3:0] VGP_IDX_SET_RESET_VALUE = 4'h0;
  localparam logic [3:0] VGP_IDX_SET_RESET_ENABLE = 4'h1;
  localparam logic [3:0] VGP_IDX_COLOR_COMPARE = 4'h2;
  localparam logic [3:0] VGP_IDX_ROTATE_AND_FUNCTION = 4'h3;
  localparam logic [3:0] VGP_IDX_READ_PLANE_SELECT = 4'h4;
  localparam logic [3:0] VGP_IDX_GRAPHICS_MODE_CONTROL = 4'h5;
  localparam logic [3:0] VGP_IDX_COMPARE_PLANE_INCLUDE = 4'h7;
  localparam logic [3:0] VGP_IDX_WRITE_BIT_MASK = 4'h8;

  // Port select values: index port and data port.
  localparam logic VGP_PORT_INDEX = 1'b0;
  localparam logic VGP_PORT_DATA = 1'b1;

  // Field positions of the graphics mode control register.
  localparam int VGP_MODE_SHIFT_HI = 6;
  localparam int VGP_MODE_SHIFT_LO = 5;
  localparam int VGP_MODE_ODD_EVEN = 4;
  localparam int VGP_MODE_READ = 3;
  localparam int VGP_MODE_WRITE_HI = 1;
  localparam int VGP_MODE_WRITE_LO = 0;
  localparam logic [7:0] VGP_MODE_RW_MASK = 8'h7B;

  // Field positions of the rotate and function register.
  localparam int VGP_FUNC_HI = 4;
  localparam int VGP_FUNC_LO = 3;
  localparam int VGP_ROT_HI = 2;
  localparam int VGP_ROT_LO = 0;

  // Reset values.
  localparam logic [7:0] VGP_RESET_REG = 8'h00;
  localparam logic [7:0] VGP_RESET_BIT_MASK = 8'hFF;

  // Serializer transfers per loaded plane byte set.
  localparam int VGP_XFERS_PER_LOAD = 8;

  typedef enum logic [1:0] {
    VGP_FN_PASS,
    VGP_FN_AND,
    VGP_FN_OR,
    VGP_FN_XOR
  } vgp_func_t;

  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } vgp_planes_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } vgp_cpu_mem_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [3:0] plane_en;
    vgp_planes_t wdata;
  } vgp_fb_req_t;

endpackage

// *** hw/vgp_serializer.sv ***
`timescale 1ns/1ps

module vgp_serializer #(
  parameter int XFERS = vgp_pkg::VGP_XFERS_PER_LOAD
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Shift format and pixel timing.
  input wire logic [1:0] shift_fmt_in,
  input wire logic pix_en_in,
  // Plane bytes from the display fetch.
  input wire vgp_pkg::vgp_planes_t planes_in,
  output logic load_out,
  // Serial pixel nibble to the palette.
  output logic [3:0] pix_out,
  output logic pix_valid_out
);
  import vgp_pkg::*;

  vgp_planes_t hold_r;
  logic [2:0] xfer_r;
  logic [3:0] pix_r;
  logic valid_r;
  logic [3:0] pix_nxt;
  logic [2:0] xfer_use;
  vgp_planes_t src;

  // A new plane set is taken on the first transfer of every group of eight.
  assign load_out = pix_en_in && (xfer_r == 3'h0);
  assign src = load_out ? planes_in : hold_r;
  assign xfer_use = xfer_r;

  always_comb begin
    pix_nxt = 4'h0;
    case (shift_fmt_in)
      2'b00: begin
        pix_nxt = {src.p3[3'd7 - xfer_use], src.p2[3'd7 - xfer_use],
                   src.p1[3'd7 - xfer_use], src.p0[3'd7 - xfer_use]};
      end
      2'b01: begin
        if (!xfer_use[2]) begin
          pix_nxt = {src.p2[3'd7 - {xfer_use[1:0], 1'b0}],
                     src.p2[3'd6 - {xfer_use[1:0], 1'b0}],
                     src.p0[3'd7 - {xfer_use[1:0], 1'b0}],
                     src.p0[3'd6 - {xfer_use[1:0], 1'b0}]};
        end else begin
          pix_nxt = {src.p3[3'd7 - {xfer_use[1:0], 1'b0}],
                     src.p3[3'd6 - {xfer_use[1:0], 1'b0}],
                     src.p1[3'd7 - {xfer_use[1:0], 1'b0}],
                     src.p1[3'd6 - {xfer_use[1:0], 1'b0}]};
        end
      end
      default: begin
        case (xfer_use[2:1])
          2'd0: pix_nxt = xfer_use[0] ? src.p0[3:0] : src.p0[7:4];
          2'd1: pix_nxt = xfer_use[0] ? src.p1[3:0] : src.p1[7:4];
          2'd2: pix_nxt = xfer_use[0] ? src.p2[3:0] : src.p2[7:4];
          default: pix_nxt = xfer_use[0] ? src.p3[3:0] : src.p3[7:4];
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      hold_r <= '0;
      xfer_r <= 3'h0;
      pix_r <= 4'h0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= pix_en_in;
      if (pix_en_in) begin
        pix_r <= pix_nxt;
        xfer_r <= (xfer_r == 3'(XFERS - 1)) ? 3'h0 : 3'(xfer_r + 3'h1);
        if (load_out) begin
          hold_r <= planes_in;
        end
      end
    end
  end

  assign pix_out = pix_r;
  assign pix_valid_out = valid_r;

endmodule

// *** hw/vgp_graphics_ctrl.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Mode register: shift format 6-5, odd/even 4, read mode 3, write mode 1-0.
// - Format 00: eight transfers, output n carries plane n bit 7 down to 0.
// - Format 01: planes 0/2 bit pairs first four transfers, planes 1/3 last four.
// - Format 1x: upper then lower nibble of planes 0,1,2,3 in turn.
// - Odd/even off: sequential addressing, planes chosen by plane write mask.
// - Odd/even on: address bit 0 picks planes 0/2 or 1/3.
// - Read mode 0 returns byte of plane given by read plane select, with address bit 0 as its low bit when odd/even is on.
// - Read mode 1 returns per-bit colour compare over included planes.
// - Write mode 0: rotated byte, or replicated set/reset bit where enabled.
// - Write mode 1: every plane written from its read latch.
// - Read latches hold unmodified plane bytes of the latest frame-buffer read.
// - Write mode 2: low four CPU bits form colour, mask selects colour bits.
// - Write mode 2: masked-off bit positions come from the read latches.
// - Write mode 3: rotated data ANDed with mask gates set/reset colour.
// - CPU write data is rotated right by the rotate count in write modes 0 and 3; write mode 2 uses it unrotated.
// - Logic function with latch: pass, AND, OR or XOR.
// - Bit mask applies to CPU writes in write modes 0, 2 and 3, not mode 1; zero bits take latch values.
module vgp_graphics_ctrl (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Indexed register I/O from the host.
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic io_port_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Plane write mask from the sequencer.
  input wire logic [3:0] plane_write_mask_in,
  // Host frame-buffer access.
  input wire vgp_pkg::vgp_cpu_mem_t cpu_in,
  output logic cpu_ack_out,
  output logic [7:0] cpu_rdata_out,
  // Frame-buffer planes.
  output vgp_pkg::vgp_fb_req_t fb_out,
  input wire logic fb_ack_in,
  input wire vgp_pkg::vgp_planes_t fb_rdata_in,
  // Display fetch and serial pixels to the palette.
  input wire logic pix_en_in,
  input wire vgp_pkg::vgp_planes_t disp_planes_in,
  output logic disp_load_out,
  output logic [3:0] pix_out,
  output logic pix_valid_out
);
  import vgp_pkg::*;

  typedef enum logic [1:0] {
    VGP_ST_IDLE,
    VGP_ST_WAIT,
    VGP_ST_DONE
  } vgp_state_t;

  logic [3:0] index_r;
  logic [3:0] set_reset_value_r;
  logic [3:0] set_reset_enable_r;
  logic [3:0] color_compare_r;
  logic [7:0] rotate_and_function_r;
  logic [1:0] read_plane_select_r;
  logic [7:0] graphics_mode_control_r;
  logic [3:0] compare_plane_include_r;
  logic [7:0] write_bit_mask_r;
  vgp_planes_t latch_r;
  vgp_state_t state_r;
  vgp_state_t state_nxt;
  vgp_fb_req_t fb_r;
  logic ack_r;
  logic [7:0] cpu_rdata_r;
  logic [7:0] io_rdata_r;

  // Decoded mode fields.
  wire logic [1:0] shift_fmt = graphics_mode_control_r[VGP_MODE_SHIFT_HI:VGP_MODE_SHIFT_LO];
  wire logic odd_even = graphics_mode_control_r[VGP_MODE_ODD_EVEN];
  wire logic read_mode = graphics_mode_control_r[VGP_MODE_READ];
  wire logic [1:0] write_mode = graphics_mode_control_r[VGP_MODE_WRITE_HI:VGP_MODE_WRITE_LO];
  wire logic [2:0] rot_cnt = rotate_and_function_r[VGP_ROT_HI:VGP_ROT_LO];
  wire vgp_func_t func_sel = vgp_func_t'(rotate_and_function_r[VGP_FUNC_HI:VGP_FUNC_LO]);

  wire logic data_wr = io_wr_in && (io_port_in == VGP_PORT_DATA);
  wire logic index_wr = io_wr_in && (io_port_in == VGP_PORT_INDEX);

  // The low byte of the doubled word shifted right is the rotated byte.
  function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] dd;
    dd = {d, d} >> n;
    return dd[7:0];
  endfunction

  function automatic logic [7:0] alu(input vgp_func_t f, input logic [7:0] d,
                                     input logic [7:0] l);
    case (f)
      VGP_FN_AND: alu = d & l;
      VGP_FN_OR: alu = d | l;
      VGP_FN_XOR: alu = d ^ l;
      default: alu = d;
    endcase
  endfunction

  // Picks one plane byte out of a set of four.
  function automatic logic [7:0] plane_of(input vgp_planes_t p, input logic [1:0] n);
    case (n)
      2'd0: plane_of = p.p0;
      2'd1: plane_of = p.p1;
      2'd2: plane_of = p.p2;
      default: plane_of = p.p3;
    endcase
  endfunction

  // Plane selection for a host access. Odd/even writes stay inside the mask.
  wire logic [3:0] plane_sel = odd_even ?
                               (cpu_in.addr[0] ? 4'hA : 4'h5) & plane_write_mask_in :
                               plane_write_mask_in;
  // In odd/even the read plane pair follows the address bit 0 kept in the request.
  wire logic [1:0] read_plane = odd_even ?
                                {read_plane_select_r[1], fb_r.addr[0]} :
                                read_plane_select_r;

  // Write data path, built per plane. It uses the latches as they stand when the
  // request is taken, so a write right after a read combines with that read's data.
  wire logic [7:0] rot_data = rotr(cpu_in.data, rot_cnt);
  wire logic [7:0] m3_mask = rot_data & write_bit_mask_r;
  logic [7:0] wr_plane [4];
  logic [7:0] latch_plane [4];
  assign latch_plane[0] = plane_of(latch_r, 2'd0);
  assign latch_plane[1] = plane_of(latch_r, 2'd1);
  assign latch_plane[2] = plane_of(latch_r, 2'd2);
  assign latch_plane[3] = plane_of(latch_r, 2'd3);

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_plane
      wire logic [7:0] sr_byte = {8{set_reset_value_r[gp]}};
      wire logic [7:0] m0_src = set_reset_enable_r[gp] ? sr_byte : rot_data;
      wire logic [7:0] m0_fn = alu(func_sel, m0_src, latch_plane[gp]);
      wire logic [7:0] m2_fn = alu(func_sel, {8{cpu_in.data[gp]}}, latch_plane[gp]);
      wire logic [7:0] m3_fn = alu(func_sel, sr_byte, latch_plane[gp]);
      always_comb begin
        case (write_mode)
          2'd0: begin
            wr_plane[gp] = (m0_fn & write_bit_mask_r) |
                           (latch_plane[gp] & ~write_bit_mask_r);
          end
          2'd1: begin
            wr_plane[gp] = latch_plane[gp];
          end
          2'd2: begin
            wr_plane[gp] = (m2_fn & write_bit_mask_r) |
                           (latch_plane[gp] & ~write_bit_mask_r);
          end
          default: begin
            wr_plane[gp] = (m3_fn & m3_mask) | (latch_plane[gp] & ~m3_mask);
          end
        endcase
      end
    end
  endgenerate

  // Colour compare on the data returned by the planes.
  wire logic [7:0] cmp_result =
    ~(({8{compare_plane_include_r[0]}} & (fb_rdata_in.p0 ^ {8{color_compare_r[0]}})) |
      ({8{compare_plane_include_r[1]}} & (fb_rdata_in.p1 ^ {8{color_compare_r[1]}})) |
      ({8{compare_plane_include_r[2]}} & (fb_rdata_in.p2 ^ {8{color_compare_r[2]}})) |
      ({8{compare_plane_include_r[3]}} & (fb_rdata_in.p3 ^ {8{color_compare_r[3]}})));
  wire logic [7:0] sel_byte = plane_of(fb_rdata_in, read_plane);
  wire logic [7:0] read_result = read_mode ? cmp_result : sel_byte;

  // Access sequencer: one frame-buffer cycle per host request. A request still high
  // in the idle state after its acknowledge starts a new access.
  wire logic req_take = (state_r == VGP_ST_IDLE) && cpu_in.req;
  wire logic fb_done = (state_r == VGP_ST_WAIT) && fb_ack_in;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VGP_ST_IDLE: if (cpu_in.req) state_nxt = VGP_ST_WAIT;
      VGP_ST_WAIT: if (fb_ack_in) state_nxt = VGP_ST_DONE;
      VGP_ST_DONE: state_nxt = VGP_ST_IDLE;
      default: state_nxt = VGP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_r <= VGP_ST_IDLE;
      ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ack_r <= fb_done;
    end
  end

  // The request keeps the full host address and stands until the planes answer.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      fb_r <= '0;
    end else if (req_take) begin
      fb_r.rd <= !cpu_in.wr;
      fb_r.wr <= cpu_in.wr;
      fb_r.addr <= cpu_in.addr;
      fb_r.plane_en <= cpu_in.wr ? plane_sel : 4'hF;
      fb_r.wdata <= {wr_plane[3], wr_plane[2], wr_plane[1], wr_plane[0]};
    end else if (fb_done) begin
      fb_r.rd <= 1'b0;
      fb_r.wr <= 1'b0;
    end
  end

  // Only a completed read refreshes the latches and the host read data.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      latch_r <= '0;
      cpu_rdata_r <= VGP_RESET_REG;
    end else if (fb_done && fb_r.rd) begin
      latch_r <= fb_rdata_in;
      cpu_rdata_r <= read_result;
    end
  end

  // The plane interface sees the halved address in odd/even mode.
  wire logic [15:0] fb_half_addr = {1'b0, fb_r.addr[15:1]};
  always_comb begin
    fb_out = fb_r;
    if (odd_even) begin
      fb_out.addr = fb_half_addr;
    end
  end
  assign cpu_ack_out = ack_r;
  assign cpu_rdata_out = cpu_rdata_r;

  // The index keeps only the bits that select a register.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      index_r <= 4'h0;
    end else if (index_wr) begin
      index_r <= io_wdata_in[3:0];
    end
  end

  // Indexed registers reached through the index and data ports.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      set_reset_value_r <= 4'h0;
      set_reset_enable_r <= 4'h0;
      color_compare_r <= 4'h0;
      rotate_and_function_r <= VGP_RESET_REG;
      read_plane_select_r <= 2'h0;
      graphics_mode_control_r <= VGP_RESET_REG;
      compare_plane_include_r <= 4'h0;
      write_bit_mask_r <= VGP_RESET_BIT_MASK;
    end else if (data_wr) begin
      case (index_r)
        VGP_IDX_SET_RESET_VALUE: set_reset_value_r <= io_wdata_in[3:0];
        VGP_IDX_SET_RESET_ENABLE: set_reset_enable_r <= io_wdata_in[3:0];
        VGP_IDX_COLOR_COMPARE: color_compare_r <= io_wdata_in[3:0];
        VGP_IDX_ROTATE_AND_FUNCTION: rotate_and_function_r <= io_wdata_in & 8'h1F;
        VGP_IDX_READ_PLANE_SELECT: read_plane_select_r <= io_wdata_in[1:0];
        VGP_IDX_GRAPHICS_MODE_CONTROL: begin
          graphics_mode_control_r <= io_wdata_in & VGP_MODE_RW_MASK;
        end
        VGP_IDX_COMPARE_PLANE_INCLUDE: compare_plane_include_r <= io_wdata_in[3:0];
        VGP_IDX_WRITE_BIT_MASK: write_bit_mask_r <= io_wdata_in;
        default: ;
      endcase
    end
  end

  // Reserved bits and unknown indices read as zero.
  wire logic [7:0] data_read =
    (index_r == VGP_IDX_SET_RESET_VALUE) ? {4'h0, set_reset_value_r} :
    (index_r == VGP_IDX_SET_RESET_ENABLE) ? {4'h0, set_reset_enable_r} :
    (index_r == VGP_IDX_COLOR_COMPARE) ? {4'h0, color_compare_r} :
    (index_r == VGP_IDX_ROTATE_AND_FUNCTION) ? rotate_and_function_r :
    (index_r == VGP_IDX_READ_PLANE_SELECT) ? {6'h00, read_plane_select_r} :
    (index_r == VGP_IDX_GRAPHICS_MODE_CONTROL) ? graphics_mode_control_r :
    (index_r == VGP_IDX_COMPARE_PLANE_INCLUDE) ? {4'h0, compare_plane_include_r} :
    (index_r == VGP_IDX_WRITE_BIT_MASK) ? write_bit_mask_r : 8'h00;
  wire logic [7:0] io_read_value = (io_port_in == VGP_PORT_DATA) ? data_read : {4'h0, index_r};

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      io_rdata_r <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_r <= io_read_value;
    end
  end
  assign io_rdata_out = io_rdata_r;

  // Serial pixel path to the palette.
  vgp_serializer #(
    .XFERS(VGP_XFERS_PER_LOAD)
  ) u_ser (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .shift_fmt_in(shift_fmt),
    .pix_en_in(pix_en_in),
    .planes_in(disp_planes_in),
    .load_out(disp_load_out),
    .pix_out(pix_out),
    .pix_valid_out(pix_valid_out)
  );

endmodule

// *** test/vgp_ctrl_monitor.sv ***
`timescale 1ns/1ps
module vgp_ctrl_monitor
  import vgp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Watched ports.
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic [3:0] plane_write_mask_in,
  input wire logic cpu_ack_out,
  input wire vgp_pkg::vgp_fb_req_t fb_out,
  input wire logic fb_ack_in,
  input wire logic pix_en_in,
  input wire logic disp_load_out,
  input wire logic pix_valid_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [2:0] xfer_r;
  wire fb_busy = fb_out.rd | fb_out.wr;
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) xfer_r <= 3'h0;
    else if (pix_en_in) xfer_r <= xfer_r + 3'h1;
  end
  sequence s_fb_done;
    fb_busy && fb_ack_in;
  endsequence
  sequence s_ack_pulse;
    cpu_ack_out ##1 !cpu_ack_out;
  endsequence
  a_ack_after_done: assert property (s_fb_done |=> s_ack_pulse)
    else $error("ack missing after plane answer");
  a_ack_has_cause: assert property (cpu_ack_out |-> $past(fb_ack_in))
    else $error("ack without plane answer");
  a_fb_req_hold: assert property (
    fb_busy && !fb_ack_in |=> fb_busy && $stable(fb_out.addr))
    else $error("plane request dropped early");
  a_one_kind: assert property (!(fb_out.rd && fb_out.wr))
    else $error("read and write together");
  a_read_all_planes: assert property (fb_out.rd |-> fb_out.plane_en == 4'hF)
    else $error("read does not cover all planes");
  a_write_in_mask: assert property (
    fb_out.wr |-> (fb_out.plane_en & ~plane_write_mask_in) == 4'h0)
    else $error("write outside plane mask");
  a_load_slot: assert property (pix_en_in |-> disp_load_out == (xfer_r == 3'h0))
    else $error("load not on every eighth transfer");
  a_load_cause: assert property (disp_load_out |-> pix_en_in)
    else $error("load without pixel enable");
  a_pix_valid: assert property (pix_valid_out == $past(pix_en_in))
    else $error("pixel valid timing wrong");
  a_io_data_hold: assert property (!$past(io_rd_in) |-> $stable(io_rdata_out))
    else $error("read data changed without read");
endmodule
bind vgp_graphics_ctrl vgp_ctrl_monitor u_vgp_ctrl_monitor (.sys_clk_in, .resetn_in,
  .io_rd_in, .io_rdata_out, .plane_write_mask_in, .cpu_ack_out, .fb_out, .fb_ack_in,
  .pix_en_in, .disp_load_out, .pix_valid_out);

// *** test/vgp_plane_mem.sv ***
`timescale 1ns/1ps
module vgp_plane_mem
  import vgp_pkg::*;
(
  // Clock, reset and answer delay.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] lat_in,
  // Plane request and answer.
  input wire vgp_pkg::vgp_fb_req_t fb_in,
  output logic ack_out,
  output vgp_pkg::vgp_planes_t rdata_out
);
  vgp_planes_t mem [16];
  vgp_planes_t last_r = '0;
  logic [3:0] cnt_r;
  wire busy = fb_in.rd | fb_in.wr;
  wire [3:0] a = fb_in.addr[3:0];
  // Outside the answer cycle the bus shows the inverse, so stale data never matches.
  assign rdata_out = ack_out ? last_r : ~last_r;
  initial for (int i = 0; i < 16; i++) mem[i] = '0;
  always @(posedge sys_clk_in) begin
    if (!resetn_in || ack_out || !busy) begin
      ack_out <= 1'b0;
      cnt_r <= 4'h0;
    end else if (cnt_r == lat_in) begin
      ack_out <= 1'b1;
      last_r <= mem[a];
      for (int k = 0; k < 4; k++)
        if (fb_in.wr && fb_in.plane_en[k]) mem[a][8*k+:8] <= fb_in.wdata[8*k+:8];
    end else cnt_r <= cnt_r + 4'h1;
  end
endmodule

// *** test/tb_vgp_graphics_ctrl.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module tb_vgp_graphics_ctrl;
  import vgp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic io_port = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [3:0] plane_mask = 4'hF;
  logic pix_en = 1'b0;
  logic [3:0] lat = 4'h0;
  vgp_cpu_mem_t cpu = '0;
  vgp_planes_t disp = 32'hC35AF00F;
  wire [7:0] io_rdata;
  wire [7:0] cpu_rdata;
  wire cpu_ack;
  wire fb_ack;
  wire disp_load;
  wire pix_valid;
  wire [3:0] pix;
  wire vgp_fb_req_t fb;
  wire vgp_planes_t fb_rdata;
  int num_errors = 0;
  int total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  vgp_graphics_ctrl u_vgp_graphics_ctrl (.sys_clk_in(sys_clk), .resetn_in(resetn),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_port_in(io_port), .io_wdata_in(io_wdata),
    .io_rdata_out(io_rdata), .plane_write_mask_in(plane_mask), .cpu_in(cpu),
    .cpu_ack_out(cpu_ack), .cpu_rdata_out(cpu_rdata), .fb_out(fb), .fb_ack_in(fb_ack),
    .fb_rdata_in(fb_rdata), .pix_en_in(pix_en), .disp_planes_in(disp),
    .disp_load_out(disp_load), .pix_out(pix), .pix_valid_out(pix_valid));
  vgp_plane_mem u_vgp_plane_mem (.sys_clk_in(sys_clk), .resetn_in(resetn), .lat_in(lat),
    .fb_in(fb), .ack_out(fb_ack), .rdata_out(fb_rdata));
  task automatic io_w(input logic p, input logic [7:0] d);
    @(posedge sys_clk);
    io_wr <= 1'b1;
    io_port <= p;
    io_wdata <= d;
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask
  task automatic reg_w(input logic [3:0] i, input logic [7:0] v);
    io_w(VGP_PORT_INDEX, {4'h0, i});
    io_w(VGP_PORT_DATA, v);
  endtask
  task automatic reg_r(input logic [3:0] i, output logic [7:0] v);
    io_w(VGP_PORT_INDEX, {4'h0, i});
    @(posedge sys_clk);
    io_rd <= 1'b1;
    io_port <= VGP_PORT_DATA;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    @(posedge sys_clk);
    #1 v = io_rdata;
  endtask
  task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cpu <= {1'b1, w, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 40);
    r = cpu_rdata;
    cpu <= '0;
    `CHK(n < 40, 1'b1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] b;
    mem(1'b1, a, d, b);
  endtask
  // Reads all four planes of one address in read mode 0; this also reloads the latches.
  task automatic rd4(input logic [15:0] a, output logic [31:0] v);
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      reg_w(4'h4, 8'(k));
      mem(1'b0, a, 8'h00, b);
      v[8*k+:8] = b;
    end
  endtask
  function automatic logic [7:0] cmp_exp(input logic [31:0] p, input logic [3:0] cc,
                                         input logic [3:0] inc);
    cmp_exp = 8'hFF;
    for (int k = 0; k < 4; k++)
      if (inc[k]) cmp_exp &= ~(p[8*k+:8] ^ {8{cc[k]}});
  endfunction
  function automatic logic [3:0] pix_exp(input logic [1:0] f, input logic [31:0] p, input int i);
    int j;
    j = i % 4;
    if (f == 2'b00) return {p[31-i], p[23-i], p[15-i], p[7-i]};
    if (f == 2'b01 && i < 4) return {p[23-2*j], p[22-2*j], p[7-2*j], p[6-2*j]};
    if (f == 2'b01) return {p[31-2*j], p[30-2*j], p[15-2*j], p[14-2*j]};
    return p[8*(i/2)+4*(1-i%2)+:4];
  endfunction
  task automatic t_regs();
    logic [7:0] v;
    reg_r(4'h8, v);
    `CHK(v, VGP_RESET_BIT_MASK);
    reg_w(4'h5, 8'hFF);
    reg_r(4'h5, v);
    `CHK(v, 8'h7B);
    reg_r(4'h6, v);
    `CHK(v, 8'h00);
    reg_w(4'h5, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_write_modes();
    logic [31:0] v;
    reg_w(4'h0, 8'h05);
    reg_w(4'h1, 8'h03);
    reg_w(4'h3, 8'h03);
    wr(16'h1, 8'hB4);
    rd4(16'h1, v);
    `CHK(v, 32'h969600FF);
    reg_w(4'h5, 8'h01);
    wr(16'h2, 8'h00);
    reg_w(4'h5, 8'h00);
    rd4(16'h2, v);
    `CHK(v, 32'h969600FF);
    reg_w(4'h1, 8'h00);
    reg_w(4'h3, 8'h00);
    reg_w(4'h8, 8'h0F);
    reg_w(4'h5, 8'h02);
    wr(16'h3, 8'h06);
    reg_w(4'h5, 8'h00);
    rd4(16'h3, v);
    `CHK(v, 32'h909F0FF0);
    reg_w(4'h8, 8'h3C);
    reg_w(4'h5, 8'h03);
    wr(16'h4, 8'hF0);
    reg_w(4'h5, 8'h00);
    reg_w(4'h8, 8'hFF);
    rd4(16'h4, v);
    `CHK(v, 32'h80BF0FF0);
    $display("test write modes done");
  endtask
  task automatic t_func();
    logic [31:0] v;
    logic [31:0] e;
    for (int f = 0; f < 4; f++) begin
      rd4(16'h4, v);
      reg_w(4'h3, 8'(f << 3));
      wr(16'h5, 8'h3C);
      reg_w(4'h3, 8'h00);
      rd4(16'h5, v);
      case (f)
        0: e = {4{8'h3C}};
        1: e = {4{8'h3C}} & 32'h80BF0FF0;
        2: e = {4{8'h3C}} | 32'h80BF0FF0;
        default: e = {4{8'h3C}} ^ 32'h80BF0FF0;
      endcase
      `CHK(v, e);
    end
    $display("test logic functions done");
  endtask
  task automatic t_compare();
    logic [7:0] b;
    logic [3:0] inc;
    reg_w(4'h2, 8'h06);
    reg_w(4'h5, 8'h08);
    for (int i = 0; i < 2; i++) begin
      inc = (i == 0) ? 4'hF : 4'h4;
      reg_w(4'h7, {4'h0, inc});
      mem(1'b0, 16'h4, 8'h00, b);
      `CHK(b, cmp_exp(32'h80BF0FF0, 4'h6, inc));
    end
    reg_w(4'h5, 8'h00);
    $display("test compare done");
  endtask
  task automatic t_planes();
    logic [7:0] b;
    lat <= 4'h3;
    reg_w(4'h5, 8'h10);
    wr(16'h7, 8'h5A);
    `CHK(u_vgp_plane_mem.mem[3], 32'h5A9F5AF0);
    wr(16'h6, 8'hC3);
    `CHK(u_vgp_plane_mem.mem[3], 32'h5AC35AC3);
    reg_w(4'h4, 8'h02);
    mem(1'b0, 16'h7, 8'h00, b);
    `CHK(b, 8'h5A);
    reg_w(4'h4, 8'h00);
    mem(1'b0, 16'h6, 8'h00, b);
    `CHK(b, 8'hC3);
    reg_w(4'h5, 8'h00);
    lat <= 4'h0;
    plane_mask <= 4'h4;
    wr(16'h8, 8'h11);
    `CHK(u_vgp_plane_mem.mem[8], 32'h00110000);
    plane_mask <= 4'hF;
    $display("test plane select done");
  endtask
  task automatic t_serial();
    for (int f = 0; f < 4; f++) begin
      reg_w(4'h5, 8'(f << 5));
      disp <= ~disp;
      @(posedge sys_clk);
      pix_en <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        if (i == 7) pix_en <= 1'b0;
        #1;
        `CHK(pix, pix_exp(2'(f), disp, i));
      end
    end
    $display("test serializer done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_write_modes();
    t_func();
    t_compare();
    t_planes();
    t_serial();
    print_verdict();
  end
endmodule
